// ===== logic/fsra_pkg.sv
// Contract
// (R1) Direct commands only for registers one to three
// (R2) Opcodes 05h 35h 15h read registers 1-3
// (R3) Opcodes 01h 31h 11h write registers 1-3
// (R4) Opcode 65h plus address reads register
// (R5) Opcode 71h, address, data writes register
// (R6) Indirect addresses 01h-06h map registers 1-6
// (R7) Other indirect addresses: writes ignored, reads 00h
// (R8) Power-up copies persistent image into registers
// (R9) 50h volatile write; 06h also persistent write
// (R10) Reset clears working registers, not persistent copy
// (R11) Bit 7 protect control, read/write, reset 0
// (R12) Bit 6 granularity: 0=64kB, 1=4kB
// (R13) Bit 5 direction: 0 bottom up, 1 top down
// (R14) Bits 4:2 block protect field, reset 000
// (R15) Latch low rejects status register writes; the code also admits them with the latch low after 50h
// (R16) Latch cleared at power-up and reset
// (R17) Incomplete command leaves latch unchanged
// (R18) 06h sets latch; 50h leaves it alone
// (R19) Bit 0 busy flag, read only, reset 0
// (R20) Status read repeats fresh bytes while clocked
//
package fsra_pkg;
	localparam int FSRA_NREG = 6;
	localparam logic [7:0] FSRA_OP_RD1 = 8'h05;
	localparam logic [7:0] FSRA_OP_RD2 = 8'h35;
	localparam logic [7:0] FSRA_OP_RD3 = 8'h15;
	localparam logic [7:0] FSRA_OP_WR1 = 8'h01;
	localparam logic [7:0] FSRA_OP_WR2 = 8'h31;
	localparam logic [7:0] FSRA_OP_WR3 = 8'h11;
	localparam logic [7:0] FSRA_OP_IRD = 8'h65;
	localparam logic [7:0] FSRA_OP_IWR = 8'h71;
	localparam logic [7:0] FSRA_OP_WREN = 8'h06;
	localparam logic [7:0] FSRA_OP_VWREN = 8'h50;
	localparam logic [7:0] FSRA_ADDR_FIRST = 8'h01;
	localparam logic [7:0] FSRA_ADDR_LAST = 8'h06;
	localparam int FSRA_BIT_PCTL = 7;
	localparam int FSRA_BIT_GRAN = 6;
	localparam int FSRA_BIT_DIR = 5;
	localparam int FSRA_BP_HI = 4;
	localparam int FSRA_BP_LO = 2;
	localparam int FSRA_BIT_WEL = 1;
	localparam int FSRA_BIT_BUSY = 0;
	// Software writable bits of register one
	localparam logic [7:0] FSRA_SR1_WMASK = 8'hFC;
	localparam logic [7:0] FSRA_RESET_VAL = 8'h00;
	// Host register map
	localparam logic [1:0] FSRA_H_CTRL = 2'h0;
	localparam logic [1:0] FSRA_H_ARG = 2'h1;
	localparam logic [1:0] FSRA_H_STAT = 2'h2;
	localparam logic [1:0] FSRA_H_DATA = 2'h3;
	localparam int FSRA_SCK_DIV = 4;
endpackage : fsra_pkg

// ===== logic/fsra_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fsra_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	modport dev (input cs_n, input sck, input mosi, output miso);
	modport host (output cs_n, output sck, output mosi, input miso);
endinterface : fsra_if
`default_nettype wire

// ===== logic/fsra_device.sv
`timescale 1ns/1ps
`default_nettype none
module fsra_device import fsra_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link
	fsra_if.dev link,
	// Persistent image and internal state
	input wire logic [FSRA_NREG*8-1:0] nv_image,
	input wire logic busy_in,
	input wire logic [FSRA_NREG*8-1:0] hw_status,
	output logic nv_wr,
	output logic [2:0] nv_wr_idx,
	output logic [7:0] nv_wr_data,
	output logic [FSRA_NREG*8-1:0] regs_out,
	output logic ready
);
	// ******************************
	// Pin synchronisers
	// ******************************
	logic [1:0] cs_s_q, sck_s_q, mosi_s_q;
	logic sck_prev_q;
	always_ff @(posedge clk) begin
		cs_s_q <= {cs_s_q[0], link.cs_n};
		sck_s_q <= {sck_s_q[0], link.sck};
		mosi_s_q <= {mosi_s_q[0], link.mosi};
		sck_prev_q <= sck_s_q[1];
	end
	wire logic sel = ~cs_s_q[1];
	wire logic rise = sel & sck_s_q[1] & ~sck_prev_q;
	wire logic fall = sel & ~sck_s_q[1] & sck_prev_q;

	typedef enum logic [1:0] {
		FSRA_ST_LOAD = 2'b00,
		FSRA_ST_IDLE = 2'b01,
		FSRA_ST_RUN = 2'b10
	} fsra_dstate_e;
	fsra_dstate_e st_q;
	logic [7:0] regs_q [FSRA_NREG];
	logic [7:0] sh_q, op_q, addr_q, tx_q;
	logic [2:0] bit_q;
	logic [1:0] byte_q;
	logic wel_q, vol_q, done_q;

	function automatic logic [2:0] fsra_idx(input logic [7:0] a);
		fsra_idx = 3'(a - FSRA_ADDR_FIRST);
	endfunction : fsra_idx
	function automatic logic fsra_valid(input logic [7:0] a);
		fsra_valid = (a >= FSRA_ADDR_FIRST) && (a <= FSRA_ADDR_LAST); // R6 R7
	endfunction : fsra_valid

	// Live value of a register, busy and latch folded into register one
	function automatic logic [7:0] fsra_live(input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00; // R7
		if (fsra_valid(a)) begin
			v = regs_q[fsra_idx(a)] | hw_status[fsra_idx(a)*8 +: 8];
			if (a == FSRA_ADDR_FIRST) begin
				v[FSRA_BIT_WEL] = wel_q; // R15
				v[FSRA_BIT_BUSY] = busy_in; // R19
			end
		end
		fsra_live = v;
	endfunction : fsra_live

	wire logic [7:0] rx = {sh_q[6:0], mosi_s_q[1]};
	wire logic byte_end = rise && bit_q == 3'd7;

	// ******************************
	// Bit and byte framing
	// ******************************
	always_ff @(posedge clk) begin
		if (rst || !sel) begin
			bit_q <= 3'd0;
			byte_q <= 2'd0;
		end else if (rise) begin
			sh_q <= rx;
			bit_q <= bit_q + 3'd1;
			if (byte_end && byte_q != 2'd3) begin
				byte_q <= byte_q + 2'd1;
			end
			if (byte_end && byte_q == 2'd0) begin
				op_q <= rx;
			end
			if (byte_end && byte_q == 2'd1) begin
				addr_q <= rx;
			end
		end
	end

	// Target register for a write landing in this byte, 0 when none
	logic [7:0] wtgt;
	always_comb begin
		wtgt = 8'h00;
		if (byte_q == 2'd1) begin
			unique case (op_q)
				FSRA_OP_WR1: wtgt = 8'h01; // R3
				FSRA_OP_WR2: wtgt = 8'h02; // R3
				FSRA_OP_WR3: wtgt = 8'h03; // R1 R3
				default: wtgt = 8'h00;
			endcase
		end else if (byte_q == 2'd2 && op_q == FSRA_OP_IWR) begin
			wtgt = fsra_valid(addr_q) ? addr_q : 8'h00; // R5 R7
		end
	end
	// A volatile enable opens a write without setting the latch, so either one admits it
	wire logic wr_hit = byte_end && wtgt != 8'h00 && (wel_q || vol_q); // R9 R15

	// ******************************
	// Registers and persistent write
	// ******************************
	logic [2:0] ld_q;
	always_ff @(posedge clk) begin
		nv_wr <= 1'b0;
		if (rst) begin
			st_q <= FSRA_ST_LOAD;
			ld_q <= 3'd0;
			for (int i = 0; i < FSRA_NREG; i++) begin
				regs_q[i] <= FSRA_RESET_VAL; // R10
			end
		end else if (st_q == FSRA_ST_LOAD) begin
			// One register per cycle keeps the load path narrow
			regs_q[ld_q] <= nv_image[ld_q*8 +: 8]; // R8
			if (ld_q == 3'(FSRA_NREG-1)) begin
				st_q <= FSRA_ST_IDLE;
			end else begin
				ld_q <= ld_q + 3'd1;
			end
		end else begin
			st_q <= sel ? FSRA_ST_RUN : FSRA_ST_IDLE;
			if (wr_hit) begin
				regs_q[fsra_idx(wtgt)] <= (wtgt == FSRA_ADDR_FIRST) ? (rx & FSRA_SR1_WMASK) : rx; // R11 R12 R13 R14
				if (!vol_q) begin
					nv_wr <= 1'b1; // R9
					nv_wr_idx <= fsra_idx(wtgt);
					nv_wr_data <= rx;
				end
			end
		end
	end

	// ******************************
	// Write enable latch
	// ******************************
	always_ff @(posedge clk) begin
		if (rst || st_q == FSRA_ST_LOAD) begin
			wel_q <= 1'b0; // R16
			vol_q <= 1'b0;
			done_q <= 1'b0;
		end else if (sel) begin
			if (wr_hit) begin
				done_q <= 1'b1;
			end
			if (byte_end && byte_q == 2'd0) begin
				done_q <= (rx == FSRA_OP_WREN) || (rx == FSRA_OP_VWREN);
			end
		end else if (done_q) begin
			// Acts only once the whole command is in; aborted frames leave it
			done_q <= 1'b0; // R17
			if (op_q == FSRA_OP_WREN) begin
				wel_q <= 1'b1; // R18
				vol_q <= 1'b0; // R9
			end else if (op_q == FSRA_OP_VWREN) begin
				vol_q <= 1'b1; // R9 R18
			end else begin
				wel_q <= 1'b0;
				vol_q <= 1'b0;
			end
		end
	end

	// ******************************
	// Read shifter
	// ******************************
	logic [7:0] rsel;
	always_comb begin
		unique case (op_q)
			FSRA_OP_RD1: rsel = FSRA_ADDR_FIRST; // R2
			FSRA_OP_RD2: rsel = 8'h02; // R2
			FSRA_OP_RD3: rsel = 8'h03; // R1 R2
			FSRA_OP_IRD: rsel = addr_q; // R4
			default: rsel = 8'h00;
		endcase
	end
	// Reloaded on the fall that opens every data byte, so a poll sees fresh busy
	wire logic rd_load = (byte_q == 2'd1 && op_q != FSRA_OP_IRD) || byte_q >= 2'd2;
	always_ff @(posedge clk) begin
		if (rst || !sel) begin
			tx_q <= 8'h00;
		end else if (fall) begin
			if (bit_q == 3'd0 && rd_load) begin
				tx_q <= fsra_live(rsel); // R20
			end else begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end
	assign link.miso = tx_q[7];
	always_comb begin
		for (int i = 0; i < FSRA_NREG; i++) begin
			regs_out[i*8 +: 8] = regs_q[i];
		end
	end
	assign ready = st_q != FSRA_ST_LOAD;
endmodule : fsra_device
`default_nettype wire

// ===== logic/fsra_host.sv
`timescale 1ns/1ps
`default_nettype none
module fsra_host import fsra_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Software port
	input wire logic [1:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Link
	fsra_if.host link
);
	// ARG: [7:0] opcode, [15:8] address/data, [23:16] data, [25:24] bytes-1, [26] poll
	logic [26:0] arg_q;
	logic [7:0] data_q, rx_q;
	logic busy_q;
	logic [23:0] sh_q;
	logic [2:0] bit_q;
	logic [1:0] nb_q;
	logic [$clog2(FSRA_SCK_DIV)-1:0] div_q;
	logic sck_q, cs_q;
	logic [1:0] miso_s_q;

	always_ff @(posedge clk) begin
		miso_s_q <= {miso_s_q[0], link.miso};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			arg_q <= 27'h0;
		end else if (wr && addr == FSRA_H_ARG) begin
			arg_q <= wdata[26:0];
		end
	end

	wire logic tick = div_q == '0;
	// Byte as it stands once the bit now on miso is taken in
	wire logic [7:0] rx_byte = {rx_q[6:0], miso_s_q[1]};
	wire logic start = wr && addr == FSRA_H_CTRL && wdata[0] && !busy_q;
	wire logic fin = busy_q && tick && sck_q && bit_q == 3'd7;

	always_ff @(posedge clk) begin
		if (rst) begin
			busy_q <= 1'b0;
			cs_q <= 1'b1;
			sck_q <= 1'b0;
			div_q <= '0;
			bit_q <= 3'd0;
			nb_q <= 2'd0;
			sh_q <= 24'h0;
			rx_q <= 8'h00;
			data_q <= 8'h00;
		end else if (start) begin
			busy_q <= 1'b1;
			cs_q <= 1'b0;
			sh_q <= {arg_q[7:0], arg_q[15:8], arg_q[23:16]};
			nb_q <= arg_q[25:24];
			bit_q <= 3'd0;
			div_q <= '0;
		end else if (busy_q) begin
			div_q <= 2'(div_q + 1'b1);
			if (tick) begin
				sck_q <= ~sck_q;
				if (sck_q) begin
					// Taken at the end of the high phase: miso lags sck by the far
					// edge detect plus our synchroniser, more than half a period
					rx_q <= rx_byte;
					sh_q <= {sh_q[22:0], 1'b0};
					bit_q <= bit_q + 3'd1;
				end
			end
			if (fin) begin
				data_q <= rx_byte;
				if (nb_q != 2'd0) begin
					nb_q <= nb_q - 2'd1;
				end else if (arg_q[26] && rx_byte[FSRA_BIT_BUSY]) begin
					// Keep clocking the status byte until busy falls
					nb_q <= 2'd0; // R20
				end else begin
					busy_q <= 1'b0;
					cs_q <= 1'b1;
				end
			end
		end
	end

	assign link.cs_n = cs_q;
	assign link.sck = sck_q;
	assign link.mosi = sh_q[23];

	always_ff @(posedge clk) begin
		if (rst || !rd) begin
			rdata <= 32'h0;
		end else begin
			unique case (addr)
				FSRA_H_CTRL: rdata <= 32'h0;
				FSRA_H_ARG: rdata <= {5'h0, arg_q};
				FSRA_H_STAT: rdata <= {31'h0, busy_q};
				FSRA_H_DATA: rdata <= {24'h0, data_q};
			endcase
		end
	end
endmodule : fsra_host
`default_nettype wire

// ===== tb/fsra_props.sv
`timescale 1ns/1ps
`default_nettype none
module fsra_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso
);
	// ****************
	// Wire checks
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_idle; cs_n |-> !sck; endproperty
	a_idle: assert property (p_idle) else $error("clock moves while idle");
	property p_hi; $rose(sck) |-> sck[*4] ##1 !sck; endproperty
	a_hi: assert property (p_hi) else $error("clock high phase wrong");
	property p_lo; $fell(sck) |-> !sck[*4]; endproperty
	a_lo: assert property (p_lo) else $error("clock low phase short");
	property p_mosi; $rose(sck) |=> $stable(mosi)[*3]; endproperty
	a_mosi: assert property (p_mosi) else $error("host data moves while sampled");
	property p_sel; $fell(cs_n) |-> !sck ##[1:20] $rose(sck); endproperty
	a_sel: assert property (p_sel) else $error("no clock after select");
	property p_desel; $rose(cs_n) |-> $fell(sck); endproperty
	a_desel: assert property (p_desel) else $error("deselect away from last clock fall");
	property p_frame; $fell(cs_n) |-> !cs_n[*8]; endproperty
	a_frame: assert property (p_frame) else $error("frame too short");
	property p_hold; !cs_n && $rose(sck) |=> !cs_n[*3]; endproperty
	a_hold: assert property (p_hold) else $error("deselect mid bit");
	c_end: cover property ($rose(cs_n));
	c_out: cover property (!cs_n && sck && miso);
	c_go: cover property ($fell(cs_n) ##[1:20] $rose(sck));
endmodule : fsra_props
`default_nettype wire

// ===== tb/flash_status_register_access_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_status_register_access_tb_top import fsra_pkg::*; ;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, busy_in = 1'b0, nv_wr, ready;
	logic [1:0] addr = 2'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [47:0] nv_image = 48'h5645_3423_12A4;
	logic [47:0] regs;
	logic [2:0] nv_wr_idx;
	logic [7:0] nv_wr_data, got;
	logic [7:0] ex [1:6];
	logic [7:0] px [1:6];
	logic [7:0] rop [3] = '{FSRA_OP_RD1, FSRA_OP_RD2, FSRA_OP_RD3};
	logic [7:0] wop [3] = '{FSRA_OP_WR1, FSRA_OP_WR2, FSRA_OP_WR3};
	int miscompares = 0, check_count = 0, nv_cnt = 0;
	fsra_if link ();
	fsra_device fsra_device_i (.clk(clk), .rst(rst), .link(link.dev), .nv_image(nv_image),
		.busy_in(busy_in), .hw_status(48'h0), .nv_wr(nv_wr), .nv_wr_idx(nv_wr_idx),
		.nv_wr_data(nv_wr_data), .regs_out(regs), .ready(ready));
	fsra_host fsra_host_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .link(link.host));
	fsra_props fsra_props_i (.clk(clk), .rst(rst), .cs_n(link.cs_n), .sck(link.sck),
		.mosi(link.mosi), .miso(link.miso));
	// ****************
	// Flash image model
	// ****************
	initial begin
		forever #50 clk = ~clk;
	end
	// The image keeps what persistent writes stored, across resets
	always_ff @(posedge clk) begin
		if (nv_wr) begin
			nv_image[nv_wr_idx*8 +: 8] <= nv_wr_data;
			nv_cnt <= nv_cnt + 1;
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1 got = rdata[7:0];
	endtask : bus
	// One frame; leaves the last received byte in got
	task automatic xf(input logic [7:0] op, b1, b2, input int n, input logic poll);
		int k;
		k = 0;
		bus(FSRA_H_ARG, 1'b1, {5'h0, poll, 2'(n - 1), b2, b1, op});
		bus(FSRA_H_CTRL, 1'b1, 32'h1);
		do begin
			bus(FSRA_H_STAT, 1'b0, 32'h0);
			k++;
		end while (got[0] !== 1'b0 && k < 1000);
		chk({7'h0, got[0]}, 8'h00);
		bus(FSRA_H_DATA, 1'b0, 32'h0);
	endtask : xf
	task automatic t_load();
		for (int i = 0; i < 8; i++) begin
			xf(FSRA_OP_IRD, 8'(i), 8'h00, 3, 1'b0);
			chk(got, (i == 0 || i == 7) ? 8'h00 : ex[i]);
		end
		for (int i = 0; i < 3; i++) begin
			xf(rop[i], 8'h00, 8'h00, 2, 1'b0);
			chk(got, ex[i+1]);
		end
	endtask : t_load
	task automatic restart(input int n);
		int k;
		k = 0;
		@(posedge clk);
		rst <= 1'b1;
		repeat (n) @(posedge clk);
		rst <= 1'b0;
		ex = px;
		do begin
			@(negedge clk);
			k++;
		end while (ready !== 1'b1 && k < 100);
		t_load();
	endtask : restart
	task automatic t_write();
		xf(FSRA_OP_WR1, 8'hFF, 8'h00, 2, 1'b0);
		xf(FSRA_OP_WREN, 8'h00, 8'h00, 1, 1'b0);
		xf(FSRA_OP_RD1, 8'h00, 8'h00, 2, 1'b0);
		chk(got, ex[1] | 8'h02);
		for (int i = 1; i <= 3; i++) begin
			xf(FSRA_OP_WREN, 8'h00, 8'h00, 1, 1'b0);
			xf(wop[i-1], 8'hE8 ^ 8'(i), 8'h00, 2, 1'b0);
			ex[i] = (8'hE8 ^ 8'(i)) & ((i == 1) ? FSRA_SR1_WMASK : 8'hFF);
			px[i] = ex[i];
			xf(FSRA_OP_IRD, 8'(i), 8'h00, 3, 1'b0);
			chk(got, ex[i]);
			chk(8'(nv_cnt), 8'(i));
		end
	endtask : t_write
	task automatic t_vol();
		xf(FSRA_OP_VWREN, 8'h00, 8'h00, 1, 1'b0);
		xf(FSRA_OP_IWR, 8'h05, 8'h3C, 3, 1'b0);
		ex[5] = 8'h3C;
		xf(FSRA_OP_IRD, 8'h05, 8'h00, 3, 1'b0);
		chk(got, ex[5]);
		chk(regs[39:32], ex[5]);
		xf(FSRA_OP_WREN, 8'h00, 8'h00, 1, 1'b0);
		xf(FSRA_OP_IWR, 8'h07, 8'hAA, 3, 1'b0);
		chk(8'(nv_cnt), 8'h03);
	endtask : t_vol
	task automatic t_partial();
		xf(FSRA_OP_WREN, 8'h00, 8'h00, 1, 1'b0);
		xf(FSRA_OP_WR1, 8'h00, 8'h00, 1, 1'b0);
		xf(FSRA_OP_RD1, 8'h00, 8'h00, 2, 1'b0);
		chk(got, ex[1] | 8'h02);
	endtask : t_partial
	task automatic t_poll();
		time t0;
		@(posedge clk);
		busy_in <= 1'b1;
		t0 = $time;
		fork
			xf(FSRA_OP_RD1, 8'h00, 8'h00, 2, 1'b1);
			begin
				repeat (500) @(posedge clk);
				busy_in <= 1'b0;
			end
		join
		chk(got, ex[1] | 8'h02);
		chk(8'($time - t0 > 50000), 8'h01);
	endtask : t_poll
	task automatic print_verdict();
		if (miscompares == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		$display("mismatch at %0t: timeout", $time);
		print_verdict();
	end
	initial begin
		for (int i = 1; i <= 6; i++) begin
			px[i] = nv_image[(i-1)*8 +: 8];
		end
		restart(2);
		t_write();
		t_vol();
		t_partial();
		t_poll();
		xf(FSRA_OP_WREN, 8'h00, 8'h00, 1, 1'b0);
		// Volatile value of register five must not survive this
		restart(1);
		print_verdict();
	end
endmodule : flash_status_register_access_tb_top
`default_nettype wire
